// ### sim/ldc_line_model.sv
// line side model: received bits and transmit bit requests
`default_nettype none
module ldc_line_model (
	input  wire logic pclk,
	output var  logic rx_bit_stb,
	output var  logic rx_data,
	output var  logic code_violation_event,
	output var  logic prbs_error_event,
	output var  logic tx_bit_stb
);
	timeunit 1ns;
	timeprecision 1ps;
	// idle lines at time zero
	initial begin
		rx_bit_stb = 1'b0;
		rx_data = 1'b0;
		code_violation_event = 1'b0;
		prbs_error_event = 1'b0;
		tx_bit_stb = 1'b0;
	end
	// one bit; data held well past the sync delay, then inverted
	task automatic send_bit(input logic d, input logic cv, input logic pe);
		@(posedge pclk);
		rx_data <= d;
		code_violation_event <= cv;
		prbs_error_event <= pe;
		rx_bit_stb <= 1'b1;
		repeat (3) @(posedge pclk);
		rx_bit_stb <= 1'b0;
		repeat (3) @(posedge pclk);
		rx_data <= ~d; // stale value never shown
		code_violation_event <= ~cv;
		prbs_error_event <= ~pe;
	endtask
	// one transmit bit request, strobe levels 3+ cycles each
	task automatic tx_tick();
		@(posedge pclk);
		tx_bit_stb <= 1'b1;
		repeat (3) @(posedge pclk);
		tx_bit_stb <= 1'b0;
		repeat (4) @(posedge pclk);
	endtask
endmodule // ldc_line_model
`default_nettype wire

// ### sim/tb_top.sv
// self-checking bench for the line diagnostic block
`default_nettype none
`define CHK(nm, e, g) begin checks_done++; if ((g) !== (e)) begin fails++; \
	$display("mismatch %s exp %0h got %0h", nm, e, g); end end
module tb_top import ldc_pkg::*;;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int SEC = 64; // short second keeps the run brief
	logic        pclk = 1'b0;
	logic        presetn, ce, psel, penable, pwrite;
	logic [7:0]  paddr;
	logic [31:0] pwdata, prdata, rd;
	logic        pready, pslverr, irq, er;
	logic        rx_bit_stb, rx_data, code_violation_event, prbs_error_event;
	logic        tx_bit_stb, tx_code_bit, tx_code_valid;
	logic        tx_violation_insert, tx_logic_error_insert;
	int          fails = 0, checks_done = 0, viol_n = 0, lerr_n = 0;

	always #20 pclk = ~pclk;

	ldc_top #(.SECOND_LEN(SEC)) i_dut (.pclk(pclk), .presetn(presetn), .ce(ce),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.irq(irq), .rx_bit_stb(rx_bit_stb), .rx_data(rx_data),
		.code_violation_event(code_violation_event),
		.prbs_error_event(prbs_error_event), .tx_bit_stb(tx_bit_stb),
		.tx_code_bit(tx_code_bit), .tx_code_valid(tx_code_valid),
		.tx_violation_insert(tx_violation_insert),
		.tx_logic_error_insert(tx_logic_error_insert));

	ldc_line_model i_line (.pclk(pclk), .rx_bit_stb(rx_bit_stb), .rx_data(rx_data),
		.code_violation_event(code_violation_event),
		.prbs_error_event(prbs_error_event), .tx_bit_stb(tx_bit_stb));

	// insertion pulses last one cycle, so count every edge
	always @(posedge pclk) begin
		if (tx_violation_insert === 1'b1) viol_n++;
		if (tx_logic_error_insert === 1'b1) lerr_n++;
	end

	// ------------------------------------------------------------
	// bus tasks
	// ------------------------------------------------------------
	task automatic apb(input logic w, input logic [5:0] idx, input logic [31:0] wd);
		int n;
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= {idx, 2'b00};
		pwdata <= wd;
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 16);
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		if (n >= 16) begin
			fails++;
			results();
		end
	endtask
	task automatic wr(input logic [5:0] idx, input logic [7:0] d);
		apb(1'b1, idx, {24'h0, d});
	endtask
	task automatic rchk(input string nm, input logic [5:0] idx, input logic [7:0] e);
		apb(1'b0, idx, 32'h0);
		`CHK(nm, {24'h0, e}, rd)
	endtask
	// clear the tick flag, then wait for the next one on irq
	task automatic wait_tick();
		int n;
		wr(IDX_IRQ_STATUS, 8'h08);
		repeat (2) @(posedge pclk);
		n = 0;
		while (irq !== 1'b1 && n < 200) begin
			@(posedge pclk);
			n++;
		end
		if (n >= 200) begin
			fails++;
			results();
		end
	endtask

	// ------------------------------------------------------------
	// scenarios
	// ------------------------------------------------------------
	task automatic sc_reset();
		rchk("tx code rst", IDX_TX_CODE, 8'h01);
		rchk("act rst", IDX_RX_ACT, 8'h01);
		rchk("deact rst", IDX_RX_DEACT, 8'h09);
		rchk("len rst", IDX_LENGTHS, 8'h01);
		rchk("ctrl rst", IDX_ERR_CTRL, 8'h00);
		apb(1'b0, 6'h01, 32'h0);
		`CHK("unmapped err", 1'b1, er)
		`CHK("unmapped data", 32'h0, rd)
	endtask
	// default codes sent three times, msb first
	task automatic sc_match();
		logic [15:0] pat;
		pat = 16'h4CB3;
		wr(IDX_IRQ_STATUS, 8'h06);
		repeat (3) for (int i = 4; i >= 0; i--) i_line.send_bit(i == 0, 1'b0, 1'b0);
		apb(1'b0, IDX_IRQ_STATUS, 32'h0);
		`CHK("act match", 2'b01, rd[2:1])
		wr(IDX_IRQ_STATUS, 8'h06);
		repeat (3) for (int i = 5; i >= 0; i--) i_line.send_bit(i % 3 == 0, 1'b0, 1'b0);
		apb(1'b0, IDX_IRQ_STATUS, 32'h0);
		`CHK("deact match", 2'b10, rd[2:1])
		// an eight-bit activate code needs two whole copies in a row
		wr(IDX_LENGTHS, 8'h0D);
		wr(IDX_RX_ACT, 8'hB3);
		rchk("act rw", IDX_RX_ACT, 8'hB3);
		wr(IDX_IRQ_STATUS, 8'h06);
		for (int i = 15; i >= 0; i--) i_line.send_bit(pat[i], 1'b0, 1'b0);
		apb(1'b0, IDX_IRQ_STATUS, 32'h0);
		`CHK("act one copy", 2'b00, rd[2:1])
		for (int i = 7; i >= 0; i--) i_line.send_bit(pat[i], 1'b0, 1'b0);
		apb(1'b0, IDX_IRQ_STATUS, 32'h0);
		`CHK("act 8 bit", 2'b01, rd[2:1])
	endtask
	// phase is free, so accept any rotation of the low bits
	task automatic check_tx(input logic [1:0] len, input logic [7:0] code);
		int L;
		logic [15:0] v;
		logic ok, hit;
		L = 5 + len;
		wr(IDX_LENGTHS, {2'b00, len, 4'b0001});
		wr(IDX_TX_CODE, code);
		rchk("tx code rw", IDX_TX_CODE, code);
		repeat (L) i_line.tx_tick();
		for (int i = 0; i < 2 * L; i++) begin
			i_line.tx_tick();
			v[i] = tx_code_bit;
		end
		ok = 1'b0;
		for (int r = 0; r < L; r++) begin
			hit = 1'b1;
			for (int i = 0; i < 2 * L; i++)
				if (v[i] !== code[L - 1 - ((i + r) % L)]) hit = 1'b0;
			ok |= hit;
		end
		`CHK("tx code bits", 1'b1, ok)
	endtask
	task automatic sc_tx();
		wr(IDX_PATTERN, 8'h00);
		repeat (3) @(posedge pclk);
		`CHK("code valid off", 1'b0, tx_code_valid)
		wr(IDX_PATTERN, 8'h60);
		repeat (3) @(posedge pclk);
		`CHK("code valid on", 1'b1, tx_code_valid)
		check_tx(2'b00, 8'hB3);
		check_tx(2'b01, 8'hB3);
		check_tx(2'b10, 8'h8E);
		check_tx(2'b11, 8'hB3);
		wr(IDX_LENGTHS, 8'h01);
	endtask
	task automatic sc_inject();
		int v0;
		v0 = viol_n;
		wr(IDX_ERR_CTRL, 8'h40);
		repeat (3) i_line.tx_tick();
		`CHK("one violation", v0 + 1, viol_n)
		wr(IDX_ERR_CTRL, 8'h40);
		repeat (3) i_line.tx_tick();
		`CHK("held violation", v0 + 1, viol_n)
		wr(IDX_ERR_CTRL, 8'h00);
		wr(IDX_ERR_CTRL, 8'h40);
		repeat (3) i_line.tx_tick();
		`CHK("second violation", v0 + 2, viol_n)
		wr(IDX_PATTERN, 8'h40);
		wr(IDX_ERR_CTRL, 8'h00);
		v0 = lerr_n;
		wr(IDX_ERR_CTRL, 8'h20);
		repeat (3) i_line.tx_tick();
		wr(IDX_ERR_CTRL, 8'h20);
		repeat (3) i_line.tx_tick();
		`CHK("one logic error", v0 + 1, lerr_n)
		wr(IDX_ERR_CTRL, 8'h00);
	endtask
	// 2 pattern errors, 3 violations, one run of 16 zeros
	task automatic count_case(input logic [1:0] src, input logic zr, input logic [7:0] e);
		logic [7:0] c;
		c = {3'b000, zr, src, 2'b00};
		wr(IDX_ERR_CTRL, c | 8'h01);
		wr(IDX_ERR_CTRL, c);
		repeat (2) i_line.send_bit(1'b1, 1'b0, 1'b1);
		repeat (3) i_line.send_bit(1'b1, 1'b1, 1'b0);
		repeat (16) i_line.send_bit(1'b0, 1'b0, 1'b0);
		i_line.send_bit(1'b1, 1'b0, 1'b0);
		wr(IDX_ERR_CTRL, c | 8'h01);
		rchk("count low", IDX_HOLD_LOW, e);
		rchk("count high", IDX_HOLD_HIGH, 8'h00);
		wr(IDX_ERR_CTRL, c);
	endtask
	task automatic sc_count();
		count_case(SRC_LOGIC, 1'b0, 8'h02);
		count_case(SRC_ZEROS, 1'b0, 8'h01);
		count_case(SRC_ZEROS, 1'b1, 8'h00);
		count_case(SRC_CV, 1'b0, 8'h03);
		count_case(SRC_BOTH, 1'b0, 8'h04);
		wr(IDX_ERR_CTRL, 8'h09);
		repeat (2) i_line.send_bit(1'b1, 1'b1, 1'b0);
		wr(IDX_ERR_CTRL, 8'h09);
		rchk("held transfer", IDX_HOLD_LOW, 8'h00);
		wr(IDX_ERR_CTRL, 8'h08);
		wr(IDX_ERR_CTRL, 8'h09);
		rchk("fresh transfer", IDX_HOLD_LOW, 8'h02);
		wr(IDX_ERR_CTRL, 8'h08);
	endtask
	task automatic sc_irq();
		wr(IDX_IRQ_MASK, 8'h08);
		wait_tick();
		wr(IDX_IRQ_STATUS, 8'h08);
		repeat (2) @(posedge pclk);
		`CHK("irq cleared", 1'b0, irq)
		wr(IDX_IRQ_MASK, 8'h00);
		i_line.send_bit(1'b1, 1'b1, 1'b0);
		repeat (SEC + 6) @(posedge pclk);
		`CHK("irq masked", 1'b0, irq)
		apb(1'b0, IDX_IRQ_STATUS, 32'h0);
		`CHK("tick status", 1'b1, rd[3])
		rchk("manual hold", IDX_HOLD_LOW, 8'h02);
		wr(IDX_IRQ_MASK, 8'h08);
		wr(IDX_ERR_CTRL, 8'h0A);
		wait_tick();
		repeat (2) i_line.send_bit(1'b1, 1'b1, 1'b0);
		wait_tick();
		rchk("auto hold", IDX_HOLD_LOW, 8'h02);
	endtask

	task automatic results();
		$display("checks %0d fails %0d", checks_done, fails);
		if (fails == 0 && checks_done > 0) $display("Simulation passed");
		else $display("Simulation failed");
		$finish;
	endtask

	// main sequence after a 6-cycle reset
	initial begin
		presetn = 1'b0;
		ce = 1'b1;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0;
		repeat (6) @(posedge pclk);
		presetn <= 1'b1;
		sc_reset();
		sc_match();
		sc_tx();
		sc_inject();
		sc_count();
		sc_irq();
		results();
	end
	// watchdog, well beyond the expected run
	initial begin
		repeat (40000) @(posedge pclk);
		fails++;
		results();
	end
endmodule // tb_top
`default_nettype wire

// ### src/ldc_pkg.sv
// constants and types for the line diagnostic code and error count block
`default_nettype none
package ldc_pkg;
	// ------------------------------------------------------------
	// register indices (byte address is four times the index)
	// ------------------------------------------------------------
	localparam logic [5:0] IDX_PATTERN    = 6'h0C;
	localparam logic [5:0] IDX_LENGTHS    = 6'h0E;
	localparam logic [5:0] IDX_TX_CODE    = 6'h0F;
	localparam logic [5:0] IDX_RX_ACT     = 6'h10;
	localparam logic [5:0] IDX_RX_DEACT   = 6'h11;
	localparam logic [5:0] IDX_ERR_CTRL   = 6'h12;
	localparam logic [5:0] IDX_IRQ_STATUS = 6'h13;
	localparam logic [5:0] IDX_IRQ_MASK   = 6'h14;
	localparam logic [5:0] IDX_HOLD_LOW   = 6'h19;
	localparam logic [5:0] IDX_HOLD_HIGH  = 6'h1A;
	// ------------------------------------------------------------
	// reset values
	// ------------------------------------------------------------
	localparam logic [7:0] RST_TX_CODE  = 8'h01;
	localparam logic [7:0] RST_RX_ACT   = 8'h01;
	localparam logic [7:0] RST_RX_DEACT = 8'h09;
	localparam logic [5:0] RST_LENGTHS  = 6'h01;
	// ------------------------------------------------------------
	// field positions
	// ------------------------------------------------------------
	localparam int POS_VIOL_INJ = 6;
	localparam int POS_LERR_INJ = 5;
	localparam int POS_ZRULE    = 4;
	localparam int POS_SRC_HI   = 3;
	localparam int POS_SRC_LO   = 2;
	localparam int POS_MODE     = 1;
	localparam int POS_TRF      = 0;
	localparam int IRQ_OVF      = 0;
	localparam int IRQ_ACT      = 1;
	localparam int IRQ_DEACT    = 2;
	localparam int IRQ_SECOND   = 3;
	// ------------------------------------------------------------
	// encodings and counts
	// ------------------------------------------------------------
	localparam logic [1:0] SRC_LOGIC = 2'h0;
	localparam logic [1:0] SRC_ZEROS = 2'h1;
	localparam logic [1:0] SRC_CV    = 2'h2;
	localparam logic [1:0] SRC_BOTH  = 2'h3;
	localparam logic [1:0] PAT_PRBS  = 2'h2;
	localparam logic [1:0] PAT_CODE  = 2'h3;
	localparam logic [6:0] ZRUN_ANSI = 7'h10;
	localparam logic [6:0] ZRUN_FCC  = 7'h50;
	localparam int CLK_PERIOD_NS   = 40;
	localparam int SECOND_MS       = 1000;
	localparam int SECOND_CYCLES   = SECOND_MS * 1000000 / CLK_PERIOD_NS;
	typedef enum logic [1:0] {
		LDC_IDLE_ST = 2'b01,
		LDC_ACK_ST  = 2'b10
	} ldc_apb_type;
endpackage : ldc_pkg
`default_nettype wire

// ### src/ldc_top.sv
// line diagnostic code registers, error injection and error counter
`default_nettype none
module ldc_top
	import ldc_pkg::*;
#(
	parameter int SECOND_LEN = SECOND_CYCLES
) (
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        ce,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output var  logic [31:0] prdata,
	output var  logic        pready,
	output var  logic        pslverr,
	output var  logic        irq,
	input  wire logic        rx_bit_stb,
	input  wire logic        rx_data,
	input  wire logic        code_violation_event,
	input  wire logic        prbs_error_event,
	input  wire logic        tx_bit_stb,
	output var  logic        tx_code_bit,
	output var  logic        tx_code_valid,
	output var  logic        tx_violation_insert,
	output var  logic        tx_logic_error_insert
);
	// ------------------------------------------------------------
	// helpers
	// ------------------------------------------------------------
	function automatic logic [7:0] len_mask(input logic [1:0] len);
		len_mask = 8'hFF >> (3'h3 - {1'b0, len});
	endfunction

	function automatic logic code_match(input logic [15:0] h, input logic [7:0] c,
			input logic [1:0] len);
		logic [7:0] m;
		logic [3:0] n;
		m = len_mask(len);
		n = 4'h5 + {2'b00, len};
		code_match = ((h[7:0] & m) == (c & m)) && (((h >> n) & {8'h00, m}) == {8'h00, c & m});
	endfunction

	// ------------------------------------------------------------
	// pin synchronisers
	// ------------------------------------------------------------
	logic [4:0] sync1_ff, sync2_ff, sync3_ff;
	logic       rx_tick, tx_tick;
	// two flops for every pin, third only for edge finding
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sync1_ff <= 5'h00;
			sync2_ff <= 5'h00;
			sync3_ff <= 5'h00;
		end else if (ce) begin
			sync1_ff <= {tx_bit_stb, prbs_error_event, code_violation_event, rx_data, rx_bit_stb};
			sync2_ff <= sync1_ff;
			sync3_ff <= sync2_ff;
		end
	end
	assign rx_tick = sync2_ff[0] & ~sync3_ff[0];
	assign tx_tick = sync2_ff[4] & ~sync3_ff[4];

	// ------------------------------------------------------------
	// apb slave and registers
	// ------------------------------------------------------------
	ldc_apb_type apb_ff;
	logic [7:0]  tx_code_ff, act_code_ff, deact_code_ff;
	logic [6:0]  ctrl_ff;
	logic [5:0]  len_ff;
	logic [1:0]  tx_pattern_select_ff;
	logic [15:0] hold_ff, count_ff;
	logic [3:0]  irq_stat_ff, irq_mask_ff, irq_set;
	logic [31:0] prdata_ff, nxt_prdata;
	logic        pready_ff, pslverr_ff, nxt_err;
	logic        access, wr;
	logic [5:0]  idx;

	assign idx    = paddr[7:2];
	assign access = psel & penable & (apb_ff == LDC_IDLE_ST);
	assign wr     = psel & penable & pready_ff & pwrite & ~nxt_err; // lands as pready completes

	// read mux and address decode
	always_comb begin
		nxt_prdata = 32'h0000_0000;
		nxt_err    = (paddr[1:0] != 2'h0);
		case (idx)
			IDX_PATTERN:    nxt_prdata[6:5] = tx_pattern_select_ff;
			IDX_LENGTHS:    nxt_prdata[5:0] = len_ff;
			IDX_TX_CODE:    nxt_prdata[7:0] = tx_code_ff;
			IDX_RX_ACT:     nxt_prdata[7:0] = act_code_ff;
			IDX_RX_DEACT:   nxt_prdata[7:0] = deact_code_ff;
			IDX_ERR_CTRL:   nxt_prdata[6:0] = ctrl_ff;
			IDX_IRQ_STATUS: nxt_prdata[3:0] = irq_stat_ff;
			IDX_IRQ_MASK:   nxt_prdata[3:0] = irq_mask_ff;
			IDX_HOLD_LOW:   nxt_prdata[7:0] = hold_ff[7:0];
			IDX_HOLD_HIGH:  nxt_prdata[7:0] = hold_ff[15:8];
			default:        nxt_err = 1'b1;
		endcase
	end

	// one wait state: answer registered in the cycle after the access phase opens
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			apb_ff     <= LDC_IDLE_ST;
			pready_ff  <= 1'b0;
			pslverr_ff <= 1'b0;
			prdata_ff  <= 32'h0000_0000;
		end else if (ce) begin
			case (apb_ff)
				LDC_IDLE_ST: begin
					pready_ff  <= access;
					pslverr_ff <= access & nxt_err;
					prdata_ff  <= (access & ~pwrite & ~nxt_err) ? nxt_prdata : 32'h0000_0000;
					if (access)
						apb_ff <= LDC_ACK_ST;
				end
				LDC_ACK_ST: begin
					pready_ff  <= 1'b0;
					pslverr_ff <= 1'b0;
					apb_ff     <= LDC_IDLE_ST;
				end
				default: apb_ff <= LDC_IDLE_ST;
			endcase
		end
	end

	// configuration registers
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			tx_code_ff    <= RST_TX_CODE;
			act_code_ff   <= RST_RX_ACT;
			deact_code_ff <= RST_RX_DEACT;
			len_ff        <= RST_LENGTHS;
			tx_pattern_select_ff       <= 2'h0;
			ctrl_ff       <= 7'h00;
			irq_mask_ff   <= 4'h0;
		end else if (ce && wr) begin
			case (idx)
				IDX_PATTERN:  tx_pattern_select_ff <= pwdata[6:5];
				IDX_LENGTHS:  len_ff <= pwdata[5:0];
				IDX_TX_CODE:  tx_code_ff <= pwdata[7:0];
				IDX_RX_ACT:   act_code_ff <= pwdata[7:0];
				IDX_RX_DEACT: deact_code_ff <= pwdata[7:0];
				IDX_ERR_CTRL: ctrl_ff <= pwdata[6:0];
				IDX_IRQ_MASK: irq_mask_ff <= pwdata[3:0];
				default:      ;
			endcase
		end
	end

	// sticky status: a new event beats a write-one clear in the same cycle
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			irq_stat_ff <= 4'h0;
		else if (ce) begin
			if (wr && idx == IDX_IRQ_STATUS)
				irq_stat_ff <= (irq_stat_ff & ~pwdata[3:0]) | irq_set;
			else
				irq_stat_ff <= irq_stat_ff | irq_set;
		end
	end

	logic irq_ff;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			irq_ff <= 1'b0;
		else if (ce)
			irq_ff <= |(irq_stat_ff & irq_mask_ff);
	end

	// ------------------------------------------------------------
	// control edge detection
	// ------------------------------------------------------------
	logic [2:0] ctl_prev_ff;
	logic       viol_rise, lerr_rise, trf_rise;
	// only a fresh zero-to-one edge acts; holding a bit high does nothing more
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			ctl_prev_ff <= 3'h0;
		else if (ce)
			ctl_prev_ff <= {ctrl_ff[POS_VIOL_INJ], ctrl_ff[POS_LERR_INJ], ctrl_ff[POS_TRF]};
	end
	assign viol_rise = ctrl_ff[POS_VIOL_INJ] & ~ctl_prev_ff[2];
	assign lerr_rise = ctrl_ff[POS_LERR_INJ] & ~ctl_prev_ff[1];
	assign trf_rise  = ctrl_ff[POS_TRF] & ~ctl_prev_ff[0];

	// ------------------------------------------------------------
	// transmit side: loop code and error insertion
	// ------------------------------------------------------------
	logic [2:0] tx_ptr_ff, tx_top, tx_cur;
	logic       viol_pend_ff, lerr_pend_ff;
	logic       tx_bit_ff, tx_val_ff, tx_viol_ff, tx_lerr_ff;
	assign tx_top = 3'h4 + {1'b0, len_ff[5:4]};
	assign tx_cur = (tx_ptr_ff > tx_top) ? tx_top : tx_ptr_ff; // clamp after a length change

	// code sent msb first from bit length-1 down to bit 0, then repeats
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			tx_ptr_ff <= 3'h4;
			tx_bit_ff <= 1'b0;
			tx_val_ff <= 1'b0;
		end else if (ce) begin
			tx_val_ff <= (tx_pattern_select_ff == PAT_CODE);
			if (tx_pattern_select_ff != PAT_CODE)
				tx_ptr_ff <= tx_top;
			else if (tx_tick) begin
				tx_bit_ff <= tx_code_ff[tx_cur];
				tx_ptr_ff <= (tx_cur == 3'h0) ? tx_top : tx_cur - 3'h1;
			end
		end
	end

	// one request pending until a transmit bit carries it: the next one for a violation, the next prbs one for a logic error
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			viol_pend_ff <= 1'b0;
			lerr_pend_ff <= 1'b0;
			tx_viol_ff   <= 1'b0;
			tx_lerr_ff   <= 1'b0;
		end else if (ce) begin
			tx_viol_ff <= tx_tick & viol_pend_ff;
			tx_lerr_ff <= tx_tick & lerr_pend_ff & (tx_pattern_select_ff == PAT_PRBS);
			if (viol_rise)
				viol_pend_ff <= 1'b1;
			else if (tx_tick)
				viol_pend_ff <= 1'b0;
			if (lerr_rise)
				lerr_pend_ff <= 1'b1;
			else if (tx_tick && tx_pattern_select_ff == PAT_PRBS)
				lerr_pend_ff <= 1'b0;
		end
	end

	// ------------------------------------------------------------
	// receive side: code match and excess zeros
	// ------------------------------------------------------------
	logic [15:0] rx_hist_ff, rx_hist_new;
	logic [6:0]  zrun_ff, zlimit;
	logic        zeros_ev, cv_ev, lerr_ev, act_hit, deact_hit;
	assign rx_hist_new = {rx_hist_ff[14:0], sync2_ff[1]}; // match includes the bit arriving now
	assign zlimit = ctrl_ff[POS_ZRULE] ? ZRUN_FCC : ZRUN_ANSI;
	assign zeros_ev = rx_tick & ~sync2_ff[1] & (zrun_ff == zlimit - 7'h01);
	assign cv_ev    = rx_tick & sync2_ff[2];
	assign lerr_ev  = rx_tick & sync2_ff[3];
	assign act_hit   = code_match(rx_hist_new, act_code_ff, len_ff[3:2]);
	assign deact_hit = code_match(rx_hist_new, deact_code_ff, len_ff[1:0]);

	// history and zero run, one event per run of zeros
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rx_hist_ff <= 16'hFFFF;
			zrun_ff    <= 7'h00;
		end else if (ce && rx_tick) begin
			rx_hist_ff <= rx_hist_new;
			if (sync2_ff[1])
				zrun_ff <= 7'h00;
			else if (zrun_ff != 7'h7F)
				zrun_ff <= zrun_ff + 7'h01;
		end
	end

	// ------------------------------------------------------------
	// error counter, one second timer and transfer
	// ------------------------------------------------------------
	logic [24:0] sec_ff;
	logic        sec_tick, xfer, ovf;
	logic [1:0]  inc;
	logic [16:0] sum;
	logic [15:0] nxt_count;
	assign sec_tick = (sec_ff == 25'(SECOND_LEN - 1));
	assign xfer = trf_rise | (ctrl_ff[POS_MODE] & sec_tick);

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			sec_ff <= 25'h0000000;
		else if (ce)
			sec_ff <= sec_tick ? 25'h0000000 : sec_ff + 25'h0000001;
	end

	// source selection and saturating add
	always_comb begin
		case (ctrl_ff[POS_SRC_HI:POS_SRC_LO])
			SRC_LOGIC: inc = {1'b0, lerr_ev};
			SRC_ZEROS: inc = {1'b0, zeros_ev};
			SRC_CV:    inc = {1'b0, cv_ev};
			SRC_BOTH:  inc = {1'b0, cv_ev} + {1'b0, zeros_ev};
			default:   inc = 2'h0;
		endcase
		sum = {1'b0, xfer ? 16'h0000 : count_ff} + {15'h0000, inc};
		ovf = sum[16];
		nxt_count = ovf ? 16'hFFFF : sum[15:0];
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			count_ff <= 16'h0000;
			hold_ff  <= 16'h0000;
		end else if (ce) begin
			count_ff <= nxt_count;
			if (xfer)
				hold_ff <= count_ff;
		end
	end

	assign irq_set = {4{ce}} & {sec_tick, deact_hit & rx_tick, act_hit & rx_tick, ovf};

	assign prdata  = prdata_ff;
	assign pready  = pready_ff;
	assign pslverr = pslverr_ff;
	assign irq     = irq_ff;
	assign tx_code_bit           = tx_bit_ff;
	assign tx_code_valid         = tx_val_ff;
	assign tx_violation_insert   = tx_viol_ff;
	assign tx_logic_error_insert = tx_lerr_ff;

	// ------------------------------------------------------------
	// assertions
	// ------------------------------------------------------------
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	property p_viol_once;
		ce && tx_viol_ff |=> !tx_viol_ff until_with viol_rise;
	endproperty
	a_viol_once: assert property (p_viol_once) else $error("second violation");
	property p_lerr_prbs;
		tx_lerr_ff |-> $past(tx_pattern_select_ff) == PAT_PRBS;
	endproperty
	a_lerr_prbs: assert property (p_lerr_prbs) else $error("logic error off prbs");
	property p_code_only;
		ce && tx_pattern_select_ff != PAT_CODE |=> !tx_code_valid;
	endproperty
	a_code_only: assert property (p_code_only) else $error("code sent wrongly");
	property p_xfer_hold;
		ce && trf_rise |=> hold_ff == $past(count_ff);
	endproperty
	a_xfer_hold: assert property (p_xfer_hold) else $error("hold not loaded");
	property p_xfer_clear;
		ce && xfer |=> count_ff <= 16'h0002;
	endproperty
	a_xfer_clear: assert property (p_xfer_clear) else $error("counter not reset");
	property p_saturate;
		ce && count_ff == 16'hFFFF && !xfer |=> count_ff == 16'hFFFF;
	endproperty
	a_saturate: assert property (p_saturate) else $error("counter wrapped");
	property p_cv_only;
		ce && !xfer && ctrl_ff[3:2] == SRC_CV && !cv_ev && count_ff != 16'hFFFF
			|=> $stable(count_ff);
	endproperty
	a_cv_only: assert property (p_cv_only) else $error("count without cv");
	property p_auto;
		ce && sec_tick && ctrl_ff[POS_MODE] |=> hold_ff == $past(count_ff);
	endproperty
	a_auto: assert property (p_auto) else $error("no auto transfer");
	property p_manual;
		ce && !trf_rise && !ctrl_ff[POS_MODE] |=> $stable(hold_ff);
	endproperty
	a_manual: assert property (p_manual) else $error("hold moved in manual");
	property p_ready_pulse;
		pready_ff && ce |=> !pready_ff;
	endproperty
	a_ready_pulse: assert property (p_ready_pulse) else $error("pready held");

	c_code_tx: cover property (tx_code_valid && tx_tick);
	c_act_hit: cover property (act_hit && rx_tick);
	c_xfer: cover property (trf_rise ##1 hold_ff != 16'h0000);
	c_ovf: cover property (ovf);
endmodule // ldc_top
`default_nettype wire
